// ### qpi_flash_command_decoder.sv
//Behaviour
//- each byte takes two serial clocks
//- 50h alone grants volatile status writes
//- 85h, four address, dummy, one byte out
//- ECh, address, mode, dummy, streaming data out
//- 12h, address, data written from address upward
//- 21h, exactly four address bytes, no data
//- 5Ch, exactly four address bytes, no data
//- DCh, exactly four address bytes, no data
//- high nibble first, bit n+4 on line n
//- B7h sets address size flag bit 8
`timescale 1ns/1ps
`default_nettype none
module qpi_flash_command_decoder
    import qpi_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_i,
    qpi_link_if.device link,
    input wire logic [7:0] mem_rd_data_i,
    input wire logic [7:0] vcfg_i,
    output logic [31:0] mem_rd_addr_o,
    output logic prog_valid_o,
    output logic [31:0] prog_addr_o,
    output logic [7:0] prog_data_o,
    output logic erase_valid_o,
    output logic [1:0] erase_kind_o,
    output logic [31:0] erase_addr_o,
    output logic write_enable_o,
    output logic vsr_write_enable_o,
    output logic [15:0] status_reg_o,
    output logic address_size_flag_o
);
    typedef struct packed {
        dev_st_t st;
        logic sck_prev;
        logic half;
        logic [3:0] hi_nib;
        logic [2:0] cnt;
        logic [7:0] op;
        logic [31:0] addr;
        logic wel;
        logic vwen;
        logic [15:0] status;
        logic out_lo;
        logic sent;
        logic [3:0] lo_nib;
        logic [3:0] dio;
        logic doe_n;
        logic prog_v;
        logic [31:0] prog_a;
        logic [7:0] prog_d;
        logic er_v;
        logic [1:0] er_kind;
        logic [31:0] er_a;
    } dev_state_t;

    dev_state_t q;
    dev_state_t n;
    logic rise;
    logic fall;
    logic [7:0] rx_byte;
    logic [7:0] tx_byte;

    always_comb begin
        n = q;
        n.prog_v = 1'b0;
        n.er_v = 1'b0;
        n.sck_prev = link.sck;
        rise = link.sck && !q.sck_prev;
        fall = !link.sck && q.sck_prev;
        rx_byte = {q.hi_nib, link.io};
        tx_byte = (q.op == OP_RD_VCFG) ? vcfg_i : mem_rd_data_i;
        if (link.cs_n) begin
            // an erase counts only when the frame closes right after its fourth address byte
            if (q.st == D_END && !q.half && is_erase(q.op)) begin
                if (q.wel) begin
                    n.er_v = 1'b1;
                    n.er_kind = erase_kind(q.op);
                    n.er_a = q.addr;
                    n.wel = 1'b0;
                end
            end
            if (q.st == D_WDATA && q.op == OP_PROG4) begin
                n.wel = 1'b0;
            end
            n.st = D_OPC;
            n.half = 1'b0;
            n.cnt = '0;
            n.doe_n = 1'b1;
            n.out_lo = 1'b0;
            n.sent = 1'b0;
        end else begin
            if (rise) begin
                if (!q.half) begin
                    n.hi_nib = link.io;
                    n.half = 1'b1;
                end else begin
                    n.half = 1'b0;
                    unique case (q.st)
                        D_OPC: begin
                            n.op = rx_byte;
                            n.cnt = '0;
                            n.st = D_ADDR;
                            unique case (rx_byte)
                                OP_WREN: begin
                                    n.wel = 1'b1;
                                    n.st = D_END;
                                end
                                OP_WRDI: begin
                                    n.wel = 1'b0;
                                    n.st = D_END;
                                end
                                OP_VSR_WEN: begin
                                    n.vwen = 1'b1;
                                    n.st = D_END;
                                end
                                OP_EN_4B: begin
                                    n.status[ADS_BIT] = 1'b1;
                                    n.st = D_END;
                                end
                                OP_EX_4B: begin
                                    n.status[ADS_BIT] = 1'b0;
                                    n.st = D_END;
                                end
                                OP_RD_VCFG, OP_QOUT_RD4, OP_PROG4: n.st = D_ADDR;
                                OP_SECT_ER4, OP_BLK32_ER4, OP_BLK64_ER4: n.st = D_ADDR;
                                default: n.st = D_IGNORE;
                            endcase
                        end
                        D_ADDR: begin
                            n.addr = {q.addr[23:0], rx_byte};
                            n.cnt = 3'(q.cnt + 1'b1);
                            if (q.cnt == 3'(ADDR_BYTES - 1'b1)) begin
                                if (q.op == OP_QOUT_RD4) begin
                                    n.st = D_MODE;
                                end else if (q.op == OP_RD_VCFG) begin
                                    n.st = D_DUMMY;
                                end else if (q.op == OP_PROG4) begin
                                    n.st = D_WDATA;
                                end else begin
                                    n.st = D_END;
                                end
                            end
                        end
                        D_MODE: n.st = D_DUMMY;
                        D_DUMMY: begin
                            n.st = D_RDATA;
                            n.out_lo = 1'b0;
                            n.sent = 1'b0;
                        end
                        D_WDATA: begin
                            if (q.wel) begin
                                n.prog_v = 1'b1;
                                n.prog_a = q.addr;
                                n.prog_d = rx_byte;
                            end
                            n.addr = q.addr + 32'h0000_0001;
                        end
                        // a byte beyond the last address byte voids an erase
                        D_END: n.st = D_IGNORE;
                        D_RDATA: n.st = D_RDATA;
                        D_IGNORE: n.st = D_IGNORE;
                    endcase
                end
            end
            // data changes on the falling edge so it is settled at the host's rising sample
            if (fall && q.st == D_RDATA) begin
                if (q.op == OP_RD_VCFG && q.sent) begin
                    n.doe_n = 1'b1;
                end else if (!q.out_lo) begin
                    n.dio = tx_byte[7:4];
                    n.lo_nib = tx_byte[3:0];
                    n.out_lo = 1'b1;
                    n.doe_n = 1'b0;
                end else begin
                    n.dio = q.lo_nib;
                    n.out_lo = 1'b0;
                    n.sent = 1'b1;
                    n.addr = q.addr + 32'h0000_0001;
                end
            end
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            q <= '0;
            q.st <= D_OPC;
            q.status <= STATUS_RST;
            q.dio <= IO_IDLE;
            q.doe_n <= 1'b1;
        end else begin
            q <= n;
        end
    end

    assign link.d_io = q.dio;
    assign link.d_oe_n = {4{q.doe_n}};
    assign mem_rd_addr_o = q.addr;
    assign prog_valid_o = q.prog_v;
    assign prog_addr_o = q.prog_a;
    assign prog_data_o = q.prog_d;
    assign erase_valid_o = q.er_v;
    assign erase_kind_o = q.er_kind;
    assign erase_addr_o = q.er_a;
    assign write_enable_o = q.wel;
    assign vsr_write_enable_o = q.vwen;
    assign status_reg_o = q.status;
    assign address_size_flag_o = q.status[ADS_BIT];
endmodule
`default_nettype wire

// ### qpi_pkg.sv
package qpi_pkg;

    localparam logic [7:0] OP_WREN = 8'h06;
    localparam logic [7:0] OP_WRDI = 8'h04;
    localparam logic [7:0] OP_VSR_WEN = 8'h50;
    localparam logic [7:0] OP_RD_VCFG = 8'h85;
    localparam logic [7:0] OP_QOUT_RD4 = 8'hEC;
    localparam logic [7:0] OP_PROG4 = 8'h12;
    localparam logic [7:0] OP_SECT_ER4 = 8'h21;
    localparam logic [7:0] OP_BLK32_ER4 = 8'h5C;
    localparam logic [7:0] OP_BLK64_ER4 = 8'hDC;
    localparam logic [7:0] OP_EN_4B = 8'hB7;
    localparam logic [7:0] OP_EX_4B = 8'hE9;

    localparam logic [2:0] ADDR_BYTES = 3'h4;
    localparam int ADS_BIT = 8;
    localparam logic [15:0] STATUS_RST = 16'h0000;
    localparam logic [3:0] IO_IDLE = 4'hF;
    localparam int FIFO_DEPTH = 8;

    typedef enum logic [1:0] {
        ER_SECTOR = 2'b00,
        ER_BLK32 = 2'b01,
        ER_BLK64 = 2'b10
    } erase_kind_t;

    typedef enum logic [2:0] {
        D_OPC = 3'b000,
        D_ADDR = 3'b001,
        D_MODE = 3'b010,
        D_DUMMY = 3'b011,
        D_RDATA = 3'b100,
        D_WDATA = 3'b101,
        D_END = 3'b110,
        D_IGNORE = 3'b111
    } dev_st_t;

    typedef enum logic [1:0] {
        H_IDLE = 2'b00,
        H_SEND = 2'b01,
        H_READ = 2'b10,
        H_CLOSE = 2'b11
    } host_st_t;

    function automatic logic is_erase(input logic [7:0] op);
        return op == OP_SECT_ER4 || op == OP_BLK32_ER4 || op == OP_BLK64_ER4;
    endfunction

    function automatic erase_kind_t erase_kind(input logic [7:0] op);
        if (op == OP_BLK32_ER4) begin
            return ER_BLK32;
        end
        if (op == OP_BLK64_ER4) begin
            return ER_BLK64;
        end
        return ER_SECTOR;
    endfunction

endpackage

// ### qpi_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface qpi_link_if;
    logic sck;
    logic cs_n;
    logic [3:0] h_io;
    logic [3:0] h_oe_n;
    logic [3:0] d_io;
    logic [3:0] d_oe_n;
    logic [3:0] io;

    // pulled-up lines; host wins a clash to keep commands intact
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            io[i] = !h_oe_n[i] ? h_io[i] : (!d_oe_n[i] ? d_io[i] : 1'b1);
        end
    end

    modport host (output sck, output cs_n, output h_io, output h_oe_n, input io);
    modport device (input sck, input cs_n, input io, output d_io, output d_oe_n);
endinterface
`default_nettype wire

// ### qpi_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module qpi_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [CW-1:0] cnt;
    } fifo_state_t;

    fifo_state_t q;
    fifo_state_t n;
    logic push;
    logic pop;

    always_comb begin
        n = q;
        push = in_valid_i && (q.cnt != CW'(DEPTH));
        pop = out_ready_i && (q.cnt != '0);
        if (push) begin
            n.mem[q.wr] = in_data_i;
            n.wr = (q.wr == AW'(DEPTH - 1)) ? '0 : AW'(q.wr + 1'b1);
        end
        if (pop) begin
            n.rd = (q.rd == AW'(DEPTH - 1)) ? '0 : AW'(q.rd + 1'b1);
        end
        n.cnt = CW'(q.cnt + CW'(push) - CW'(pop));
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign in_ready_o = q.cnt != CW'(DEPTH);
    assign out_valid_o = q.cnt != '0;
    assign out_data_o = q.mem[q.rd];
endmodule
`default_nettype wire

// ### qpi_host_controller.sv
`timescale 1ns/1ps
`default_nettype none
module qpi_host_controller
    import qpi_pkg::*;
#(
    parameter int WR_DEPTH = FIFO_DEPTH
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    qpi_link_if.host link,
    input wire logic cmd_valid_i,
    output logic cmd_ready_o,
    input wire logic [7:0] cmd_op_i,
    input wire logic [31:0] cmd_addr_i,
    input wire logic [15:0] cmd_len_i,
    input wire logic wr_valid_i,
    output logic wr_ready_o,
    input wire logic [7:0] wr_data_i,
    output logic rd_valid_o,
    output logic [7:0] rd_data_o
);
    typedef struct packed {
        host_st_t st;
        logic rdy;
        logic sck;
        logic cs_n;
        logic [3:0] io;
        logic oe_n;
        logic half;
        logic [15:0] idx;
        logic [15:0] cnt;
        logic [7:0] op;
        logic [31:0] addr;
        logic [15:0] len;
        logic [7:0] cur;
        logic rd_v;
        logic [7:0] rd_d;
    } host_state_t;

    host_state_t q;
    host_state_t n;
    logic pop;
    logic fifo_valid;
    logic [7:0] fifo_data;
    logic [15:0] hdr;
    logic [15:0] rlen;
    logic [7:0] hbyte;

    // header length in bytes: opcode, address, mode and dummy
    function automatic logic [15:0] hdr_bytes(input logic [7:0] op);
        if (op == OP_QOUT_RD4) begin
            return 16'h0007;
        end
        if (op == OP_RD_VCFG) begin
            return 16'h0006;
        end
        if (op == OP_PROG4 || is_erase(op)) begin
            return 16'h0005;
        end
        return 16'h0001;
    endfunction

    qpi_fifo #(.WIDTH(8), .DEPTH(WR_DEPTH)) u_wr_fifo (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .in_valid_i(wr_valid_i),
        .in_ready_o(wr_ready_o),
        .in_data_i(wr_data_i),
        .out_valid_o(fifo_valid),
        .out_ready_i(pop),
        .out_data_o(fifo_data)
    );

    always_comb begin
        n = q;
        n.rd_v = 1'b0;
        pop = 1'b0;
        hdr = hdr_bytes(q.op);
        rlen = (q.op == OP_QOUT_RD4) ? q.len : ((q.op == OP_RD_VCFG) ? 16'h0001 : 16'h0000);
        unique case (q.idx[2:0])
            3'h0: hbyte = q.op;
            3'h1: hbyte = q.addr[31:24];
            3'h2: hbyte = q.addr[23:16];
            3'h3: hbyte = q.addr[15:8];
            3'h4: hbyte = q.addr[7:0];
            default: hbyte = 8'h00;
        endcase
        unique case (q.st)
            H_IDLE: begin
                if (cmd_valid_i && q.rdy) begin
                    n.rdy = 1'b0;
                    n.op = cmd_op_i;
                    n.addr = cmd_addr_i;
                    n.len = cmd_len_i;
                    n.idx = '0;
                    n.half = 1'b0;
                    n.cs_n = 1'b0;
                    n.st = H_SEND;
                end
            end
            H_SEND: begin
                if (q.sck) begin
                    n.sck = 1'b0;
                end else if (q.half) begin
                    n.io = q.cur[3:0];
                    n.sck = 1'b1;
                    n.half = 1'b0;
                    n.idx = 16'(q.idx + 1'b1);
                end else if (q.idx < hdr) begin
                    n.cur = hbyte;
                    n.io = hbyte[7:4];
                    n.oe_n = 1'b0;
                    n.sck = 1'b1;
                    n.half = 1'b1;
                end else if (q.op == OP_PROG4 && 16'(q.idx - hdr) < q.len) begin
                    // an empty buffer holds the clock low, stretching the frame
                    if (fifo_valid) begin
                        pop = 1'b1;
                        n.cur = fifo_data;
                        n.io = fifo_data[7:4];
                        n.sck = 1'b1;
                        n.half = 1'b1;
                    end
                end else begin
                    n.oe_n = 1'b1;
                    n.cnt = '0;
                    n.st = (rlen != '0) ? H_READ : H_CLOSE;
                end
            end
            H_READ: begin
                if (!q.sck) begin
                    n.sck = 1'b1;
                end else begin
                    n.sck = 1'b0;
                    if (!q.half) begin
                        n.cur[7:4] = link.io;
                        n.half = 1'b1;
                    end else begin
                        n.rd_v = 1'b1;
                        n.rd_d = {q.cur[7:4], link.io};
                        n.half = 1'b0;
                        n.cnt = 16'(q.cnt + 1'b1);
                        if (16'(q.cnt + 1'b1) == rlen) begin
                            n.st = H_CLOSE;
                        end
                    end
                end
            end
            H_CLOSE: begin
                n.cs_n = 1'b1;
                n.oe_n = 1'b1;
                n.rdy = 1'b1;
                n.st = H_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            q <= '0;
            q.st <= H_IDLE;
            q.rdy <= 1'b1;
            q.cs_n <= 1'b1;
            q.io <= IO_IDLE;
            q.oe_n <= 1'b1;
        end else begin
            q <= n;
        end
    end

    assign link.sck = q.sck;
    assign link.cs_n = q.cs_n;
    assign link.h_io = q.io;
    assign link.h_oe_n = {4{q.oe_n}};
    assign cmd_ready_o = q.rdy;
    assign rd_valid_o = q.rd_v;
    assign rd_data_o = q.rd_d;
endmodule
`default_nettype wire

// ### qpi_link_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module qpi_link_assertions
    import qpi_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic [3:0] h_io,
    input wire logic [3:0] h_oe_n,
    input wire logic [3:0] d_io,
    input wire logic [3:0] d_oe_n,
    input wire logic [3:0] io
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);

    logic sck_q;
    logic [7:0] rises_q;

    // only parity matters, so wrap-around is harmless
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            sck_q <= 1'b0;
            rises_q <= 8'h00;
        end else begin
            sck_q <= sck;
            if (cs_n) begin
                rises_q <= 8'h00;
            end else if (sck && !sck_q) begin
                rises_q <= rises_q + 8'h01;
            end
        end
    end

    sequence frame_open;
        $fell(cs_n);
    endsequence

    sequence frame_close;
        $rose(cs_n);
    endsequence

    sequence first_clock;
        ##[0:2] sck;
    endsequence

    a_sck_idle_low: assert property (cs_n |-> !sck)
        else $error("clock high while deselected");
    a_sck_single_high: assert property ($rose(sck) |=> !sck)
        else $error("clock high over one cycle");
    a_frame_first_clock: assert property (frame_open |-> first_clock)
        else $error("no clock after select");
    a_frame_whole_bytes: assert property (frame_close |-> (rises_q[0] == 1'b0))
        else $error("odd clock count");
    a_close_released: assert property (frame_close |-> !sck && (h_oe_n == 4'hF))
        else $error("host still drives at close");
    a_host_oe_whole: assert property ((h_oe_n == 4'h0) || (h_oe_n == 4'hF))
        else $error("host drives part of lines");
    a_dev_oe_whole: assert property ((d_oe_n == 4'h0) || (d_oe_n == 4'hF))
        else $error("device drives part of lines");
    a_no_line_clash: assert property ((h_oe_n | d_oe_n) == 4'hF)
        else $error("line driven by both ends");
    a_idle_released: assert property (cs_n && $past(cs_n) |-> (io == IO_IDLE))
        else $error("lines driven while deselected");
    a_host_io_steady: assert property (!cs_n && !sck && (h_oe_n == 4'h0)
        && ($past(h_oe_n) == 4'h0) |-> $stable(h_io))
        else $error("host nibble changed off a clock rise");

    cover property (frame_close);
endmodule
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import qpi_pkg::*;
;
    logic mclk_i, rst_i, cmd_valid_i, cmd_ready_o, wr_valid_i, wr_ready_o, rd_valid_o;
    logic [7:0] cmd_op_i, wr_data_i, rd_data_o, mem_rd_data_i, vcfg_i, prog_data_o;
    logic [31:0] cmd_addr_i, mem_rd_addr_o, prog_addr_o, erase_addr_o;
    logic [15:0] cmd_len_i, status_reg_o;
    logic prog_valid_o, erase_valid_o, write_enable_o, vsr_write_enable_o, address_size_flag_o;
    logic [1:0] erase_kind_o;
    logic erase2_valid, wel2, sck_prev;
    logic [39:0] prog_q[$];
    logic [33:0] erase_q[$];
    logic [7:0] rd_q[$];
    logic [3:0] nib_q[$];
    int erase2_n, cycles, comparisons, miscompares;

    qpi_link_if link_inst();
    // second link: bench host breaks framing on purpose
    qpi_link_if raw_inst();

    qpi_host_controller qpi_host_controller_inst (.mclk_i(mclk_i),
        .rst_i(rst_i), .link(link_inst), .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o),
        .cmd_op_i(cmd_op_i), .cmd_addr_i(cmd_addr_i), .cmd_len_i(cmd_len_i),
        .wr_valid_i(wr_valid_i), .wr_ready_o(wr_ready_o), .wr_data_i(wr_data_i),
        .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o));
    qpi_flash_command_decoder qpi_flash_command_decoder_inst (.mclk_i(mclk_i), .rst_i(rst_i),
        .link(link_inst), .mem_rd_data_i(mem_rd_data_i), .vcfg_i(vcfg_i),
        .mem_rd_addr_o(mem_rd_addr_o), .prog_valid_o(prog_valid_o), .prog_addr_o(prog_addr_o),
        .prog_data_o(prog_data_o), .erase_valid_o(erase_valid_o), .erase_kind_o(erase_kind_o),
        .erase_addr_o(erase_addr_o), .write_enable_o(write_enable_o),
        .vsr_write_enable_o(vsr_write_enable_o), .status_reg_o(status_reg_o),
        .address_size_flag_o(address_size_flag_o));
    qpi_flash_command_decoder qpi_flash_command_decoder_raw_inst (.mclk_i(mclk_i),
        .rst_i(rst_i), .link(raw_inst), .mem_rd_data_i(mem_rd_data_i), .vcfg_i(vcfg_i),
        .mem_rd_addr_o(), .prog_valid_o(), .prog_addr_o(), .prog_data_o(),
        .erase_valid_o(erase2_valid), .erase_kind_o(), .erase_addr_o(),
        .write_enable_o(wel2), .vsr_write_enable_o(), .status_reg_o(),
        .address_size_flag_o());
    qpi_link_assertions qpi_link_assertions_inst (.mclk_i(mclk_i), .rst_i(rst_i),
        .sck(link_inst.sck), .cs_n(link_inst.cs_n), .h_io(link_inst.h_io),
        .h_oe_n(link_inst.h_oe_n), .d_io(link_inst.d_io), .d_oe_n(link_inst.d_oe_n),
        .io(link_inst.io));

    // array answers at once from the pointer
    assign mem_rd_data_i = mem_rd_addr_o[7:0] ^ 8'h5A;

    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end

    always @(posedge mclk_i) begin
        sck_prev <= link_inst.sck;
        if (prog_valid_o === 1'b1) prog_q.push_back({prog_addr_o, prog_data_o});
        if (erase_valid_o === 1'b1) erase_q.push_back({erase_kind_o, erase_addr_o});
        if (rd_valid_o === 1'b1) rd_q.push_back(rd_data_o);
        if (!link_inst.cs_n && link_inst.sck && !sck_prev) nib_q.push_back(link_inst.io);
        if (erase2_valid === 1'b1) erase2_n++;
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            complete_run();
        end
    end

    task automatic check(input bit ok, input string msg);
        comparisons++;
        if (!ok) begin
            miscompares++;
            $display("CHECK FAILED %0t %s", $time, msg);
        end
    endtask

    task automatic complete_run();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic send_cmd(input logic [7:0] op, input logic [31:0] addr, input logic [15:0] len);
        int n;
        n = 0;
        while (cmd_ready_o !== 1'b1 && n < 2000) begin
            @(posedge mclk_i);
            n++;
        end
        cmd_op_i <= op;
        cmd_addr_i <= addr;
        cmd_len_i <= len;
        cmd_valid_i <= 1'b1;
        @(posedge mclk_i);
        cmd_valid_i <= 1'b0;
        @(posedge mclk_i);
        while (cmd_ready_o !== 1'b1 && n < 2000) begin
            @(posedge mclk_i);
            n++;
        end
        // the erase pulse lands after deselect
        repeat (4) @(posedge mclk_i);
        check(n < 2000, "cmd hung");
    endtask

    task automatic t_opcode_only();
        send_cmd(OP_WREN, 32'h0, 16'h0);
        check(write_enable_o === 1'b1, "write enable not set");
        send_cmd(OP_WRDI, 32'h0, 16'h0);
        check(write_enable_o === 1'b0, "wel not cleared");
        nib_q = {};
        send_cmd(OP_VSR_WEN, 32'h0, 16'h0);
        check(vsr_write_enable_o === 1'b1, "vsr enable not set");
        check(nib_q.size() == 2, "frame length");
        check(nib_q[0] === 4'h5 && nib_q[1] === 4'h0, "opcode nibble order");
        check(write_enable_o === 1'b0, "50h set wel");
        send_cmd(OP_EN_4B, 32'h0, 16'h0);
        check(address_size_flag_o === 1'b1 && status_reg_o === 16'h0100, "flag set");
        send_cmd(OP_EX_4B, 32'h0, 16'h0);
        check(address_size_flag_o === 1'b0 && status_reg_o === 16'h0000, "flag clr");
    endtask

    task automatic t_erase();
        logic [7:0] ops [3];
        logic [31:0] a;
        ops = '{OP_SECT_ER4, OP_BLK32_ER4, OP_BLK64_ER4};
        erase_q = {};
        send_cmd(OP_SECT_ER4, 32'hA1B2C3D4, 16'h0);
        check(erase_q.size() == 0, "erase without wel");
        for (int k = 0; k < 3; k++) begin
            a = 32'hA1B2C3D4 + 32'(k);
            send_cmd(OP_WREN, 32'h0, 16'h0);
            erase_q = {};
            nib_q = {};
            send_cmd(ops[k], a, 16'h0);
            check(erase_q.size() == 1 && erase_q[0] === {2'(k), a}, "erase");
            check(nib_q.size() == 10, "erase length");
            check(nib_q[1] === ops[k][3:0] && nib_q[2] === 4'hA
                && nib_q[9] === 4'(4 + k), "addr nibbles");
            check(write_enable_o === 1'b0, "wel kept");
        end
    endtask

    task automatic t_program();
        prog_q = {};
        for (int i = 0; i < FIFO_DEPTH; i++) begin
            wr_data_i <= 8'h3C ^ 8'(i * 17);
            wr_valid_i <= 1'b1;
            @(posedge mclk_i);
        end
        // one more offer while full must be refused
        wr_data_i <= 8'hEE;
        @(posedge mclk_i);
        wr_valid_i <= 1'b0;
        @(posedge mclk_i);
        check(wr_ready_o === 1'b0, "full but ready");
        send_cmd(OP_WREN, 32'h0, 16'h0);
        send_cmd(OP_PROG4, 32'h000010FC, 16'h0008);
        check(prog_q.size() == FIFO_DEPTH, "prog count");
        for (int i = 0; i < FIFO_DEPTH; i++) begin
            check(prog_q[i] === {32'h000010FC + 32'(i), 8'h3C ^ 8'(i * 17)}, "prog byte");
        end
        check(wr_ready_o === 1'b1, "buffer not drained");
        check(write_enable_o === 1'b0, "wel kept");
    endtask

    task automatic t_reads();
        rd_q = {};
        send_cmd(OP_QOUT_RD4, 32'h89ABCDFE, 16'h0004);
        check(rd_q.size() == 4, "read count");
        for (int i = 0; i < 4; i++) begin
            check(rd_q[i] === ((8'hFE + 8'(i)) ^ 8'h5A), "read data");
        end
        rd_q = {};
        send_cmd(OP_RD_VCFG, 32'h89ABCDFE, 16'h0004);
        check(rd_q.size() == 1 && rd_q[0] === 8'h96, "config read");
    endtask

    task automatic raw_byte(input logic [7:0] b);
        for (int h = 1; h >= 0; h--) begin
            raw_inst.h_io <= b[4*h +: 4];
            raw_inst.sck <= 1'b1;
            @(posedge mclk_i);
            raw_inst.sck <= 1'b0;
            @(posedge mclk_i);
        end
    endtask

    task automatic raw_frame(input logic [47:0] bytes, input int n);
        raw_inst.cs_n <= 1'b0;
        raw_inst.h_oe_n <= 4'h0;
        @(posedge mclk_i);
        for (int i = 0; i < n; i++) begin
            raw_byte(bytes[47-8*i -: 8]);
        end
        raw_inst.h_oe_n <= 4'hF;
        raw_inst.cs_n <= 1'b1;
        repeat (4) @(posedge mclk_i);
    endtask

    task automatic t_abort();
        erase2_n = 0;
        raw_frame({OP_WREN, 40'h0}, 1);
        check(wel2 === 1'b1, "opcode not decoded");
        raw_frame({OP_SECT_ER4, 40'h00AB000000}, 3);
        check(erase2_n == 0, "partial erase");
        raw_frame({OP_WREN, 40'h0}, 1);
        raw_frame({OP_SECT_ER4, 40'h00AB000000}, 6);
        check(erase2_n == 0, "erase with extra byte");
        raw_frame({OP_WREN, 40'h0}, 1);
        raw_frame({OP_SECT_ER4, 40'h00AB000000}, 5);
        check(erase2_n == 1, "whole erase refused");
    endtask

    initial begin
        rst_i <= 1'b1;
        cmd_valid_i <= 1'b0;
        cmd_op_i <= 8'h00;
        cmd_addr_i <= 32'h0;
        cmd_len_i <= 16'h0;
        wr_valid_i <= 1'b0;
        wr_data_i <= 8'h00;
        vcfg_i <= 8'h96;
        raw_inst.sck <= 1'b0;
        raw_inst.cs_n <= 1'b1;
        raw_inst.h_io <= 4'hF;
        raw_inst.h_oe_n <= 4'hF;
        repeat (20) @(posedge mclk_i);
        rst_i <= 1'b0;
        @(posedge mclk_i);
        t_opcode_only();
        t_erase();
        t_program();
        t_reads();
        t_abort();
        complete_run();
    end
endmodule
`default_nettype wire
